// >>> hdl/esp_pkg.sv
`default_nettype none
package esp_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int BYTES = 2;
    localparam int LOW_BYTE = 0;
    localparam int HIGH_BYTE = 1;
    localparam int CLK_PERIOD_NS = 100;
    // Least strobe width seen by the memory, rounded up to whole cycles
    localparam int STROBE_NS = 150;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 4;
    localparam logic [1:0] WE_IDLE = 2'h3;
    localparam logic [16:0] ADDR_RST = 17'h00000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0] {
        ESP_IDLE = 2'h0,
        ESP_SETUP = 2'h1,
        ESP_STROBE = 2'h3,
        ESP_HOLD = 2'h2
    } esp_state_e;
endpackage
`default_nettype wire

// >>> hdl/esp_strobe_timer.sv
`default_nettype none
module esp_strobe_timer #(
    parameter int CNT_W = 4
) (
    input wire logic clk_in, // Core clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic load_in, // Load count this cycle
    input wire logic [CNT_W-1:0] count_in, // Cycles left minus one
    output logic done_out // Count reached zero
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done_out = (cnt_q == '0) && !load_in;
endmodule
`default_nettype wire

// >>> hdl/esp_sram_port.sv
`default_nettype none
module esp_sram_port #(
    parameter int STROBE_CYC = esp_pkg::STROBE_CYC
) (
    input wire logic CORE_CLOCK_IN, // Core clock, 10 MHz
    input wire logic RESETN_IN, // Async reset, active low
    input wire logic REQ_VALID_IN, // Access request
    input wire logic REQ_WRITE_IN, // 1 write, 0 read
    input wire logic [esp_pkg::ADDR_W-1:0] REQ_ADDR_IN, // Word address
    input wire logic [esp_pkg::DATA_W-1:0] REQ_WDATA_IN, // Write data
    input wire logic [esp_pkg::BYTES-1:0] REQ_BE_IN, // Byte enables for writes
    output logic REQ_READY_OUT, // Request taken when high with valid
    output logic RD_VALID_OUT, // Read data valid pulse
    output logic [esp_pkg::DATA_W-1:0] RD_DATA_OUT, // Read data
    output logic [esp_pkg::ADDR_W-1:0] MEM_ADDR_OUT, // Memory address
    output logic MEM_ADDR_OE_OUT, // Address bus driven
    input wire logic [esp_pkg::DATA_W-1:0] MEM_DATA_IN, // Data bus level
    output logic [esp_pkg::DATA_W-1:0] MEM_DATA_OUT, // Data bus drive value
    output logic MEM_DATA_OE_OUT, // Data bus driven
    output logic MEM_OE_N_OUT, // Memory output enable, active low
    output logic [esp_pkg::BYTES-1:0] MEM_WE_N_OUT, // Byte write strobes, active low
    output logic MEM_CS_N_OUT // Chip select, active low
);
    esp_pkg::esp_state_e state_q, state_d;
    logic wr_q;
    logic [esp_pkg::BYTES-1:0] be_q;
    logic take;
    logic timer_load;
    logic timer_done;

    assign take = REQ_VALID_IN && REQ_READY_OUT && (state_q == esp_pkg::ESP_IDLE);
    assign timer_load = (state_q == esp_pkg::ESP_SETUP);

    esp_strobe_timer #(
        .CNT_W(esp_pkg::TIMER_W)
    ) u_timer (
        .clk_in(CORE_CLOCK_IN),
        .rst_n_in(RESETN_IN),
        .load_in(timer_load),
        .count_in(esp_pkg::TIMER_W'(STROBE_CYC - 1)),
        .done_out(timer_done)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            esp_pkg::ESP_IDLE: begin
                if (take) begin
                    state_d = esp_pkg::ESP_SETUP;
                end
            end
            esp_pkg::ESP_SETUP: begin
                state_d = esp_pkg::ESP_STROBE;
            end
            esp_pkg::ESP_STROBE: begin
                if (timer_done) begin
                    state_d = esp_pkg::ESP_HOLD;
                end
            end
            esp_pkg::ESP_HOLD: begin
                state_d = esp_pkg::ESP_IDLE;
            end
            default: begin
                state_d = esp_pkg::ESP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_q <= esp_pkg::ESP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Ready is registered so the request path never sees a combinational loop
    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            REQ_READY_OUT <= 1'b0;
        end else begin
            REQ_READY_OUT <= (state_d == esp_pkg::ESP_IDLE);
        end
    end

    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wr_q <= 1'b0;
            be_q <= '0;
        end else if (take) begin
            wr_q <= REQ_WRITE_IN;
            be_q <= REQ_BE_IN;
        end
    end

    // Address is held for the whole access so it is stable under every strobe
    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MEM_ADDR_OUT <= esp_pkg::ADDR_RST;
            MEM_ADDR_OE_OUT <= 1'b0;
        end else if (take) begin
            MEM_ADDR_OUT <= REQ_ADDR_IN;
            MEM_ADDR_OE_OUT <= 1'b1;
        end else if (state_d == esp_pkg::ESP_IDLE) begin
            MEM_ADDR_OE_OUT <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MEM_CS_N_OUT <= 1'b1;
        end else begin
            MEM_CS_N_OUT <= !(state_d == esp_pkg::ESP_SETUP
                || state_d == esp_pkg::ESP_STROBE);
        end
    end

    // Write data stays driven through HOLD so it outlasts the strobe edge
    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MEM_DATA_OUT <= esp_pkg::DATA_RST;
            MEM_DATA_OE_OUT <= 1'b0;
        end else if (take) begin
            MEM_DATA_OUT <= REQ_WDATA_IN;
            MEM_DATA_OE_OUT <= REQ_WRITE_IN;
        end else if (state_d == esp_pkg::ESP_IDLE) begin
            MEM_DATA_OE_OUT <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MEM_WE_N_OUT <= esp_pkg::WE_IDLE;
        end else if (state_d == esp_pkg::ESP_STROBE && wr_q) begin
            MEM_WE_N_OUT[esp_pkg::LOW_BYTE] <= !be_q[esp_pkg::LOW_BYTE];
            MEM_WE_N_OUT[esp_pkg::HIGH_BYTE] <= !be_q[esp_pkg::HIGH_BYTE];
        end else begin
            MEM_WE_N_OUT <= esp_pkg::WE_IDLE;
        end
    end

    // SETUP of a read leaves the data bus undriven for a cycle before OE falls
    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MEM_OE_N_OUT <= 1'b1;
        end else begin
            MEM_OE_N_OUT <= !(state_d == esp_pkg::ESP_STROBE && !wr_q);
        end
    end

    always_ff @(posedge CORE_CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RD_DATA_OUT <= esp_pkg::DATA_RST;
            RD_VALID_OUT <= 1'b0;
        end else begin
            RD_VALID_OUT <= 1'b0;
            if (state_q == esp_pkg::ESP_STROBE && timer_done && !wr_q) begin
                RD_DATA_OUT <= MEM_DATA_IN;
                RD_VALID_OUT <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CORE_CLOCK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    data_drive_a: assert property (
        MEM_DATA_OE_OUT |-> wr_q && MEM_OE_N_OUT && state_q != esp_pkg::ESP_IDLE)
        else $error("data bus driven outside a write");
    addr_stable_a: assert property (
        !MEM_CS_N_OUT && !$past(MEM_CS_N_OUT) |-> $stable(MEM_ADDR_OUT) && MEM_ADDR_OE_OUT)
        else $error("address moved during an access");
    read_oe_a: assert property (
        take && !REQ_WRITE_IN |-> ##2 !MEM_OE_N_OUT [*2] ##1 MEM_OE_N_OUT)
        else $error("read output enable not asserted for strobe width");
    low_we_a: assert property (
        take && REQ_WRITE_IN && REQ_BE_IN[0] |-> ##2 !MEM_WE_N_OUT[0] [*2] ##1 MEM_WE_N_OUT[0])
        else $error("low byte strobe wrong");
    high_we_a: assert property (
        !MEM_WE_N_OUT[1] |-> be_q[1] && wr_q)
        else $error("high byte strobe without its enable");
    chip_sel_a: assert property (
        (!MEM_OE_N_OUT || MEM_WE_N_OUT != esp_pkg::WE_IDLE) |-> !MEM_CS_N_OUT)
        else $error("strobe without chip select");
    idle_cs_a: assert property (
        state_q == esp_pkg::ESP_IDLE |-> MEM_CS_N_OUT)
        else $error("chip select low while idle");
    reset_idle_a: assert property (@(posedge CORE_CLOCK_IN) disable iff (1'b0)
        !RESETN_IN |-> MEM_CS_N_OUT && MEM_OE_N_OUT && MEM_WE_N_OUT == esp_pkg::WE_IDLE
            && !MEM_DATA_OE_OUT && !MEM_ADDR_OE_OUT)
        else $error("pins not idle in reset");
    no_fight_a: assert property (
        $fell(MEM_OE_N_OUT) |-> !MEM_DATA_OE_OUT && !$past(MEM_DATA_OE_OUT)
            && MEM_WE_N_OUT == esp_pkg::WE_IDLE)
        else $error("output enable while data driven or writing");
    we_data_a: assert property (
        MEM_WE_N_OUT != esp_pkg::WE_IDLE |-> MEM_DATA_OE_OUT && MEM_ADDR_OE_OUT)
        else $error("write strobe without data and address driven");
    high_we_t_a: assert property (
        take && REQ_WRITE_IN && REQ_BE_IN[1] |-> ##2 !MEM_WE_N_OUT[1] [*2] ##1 MEM_WE_N_OUT[1])
        else $error("high byte strobe timing wrong");
    oe_we_excl_a: assert property (
        !MEM_OE_N_OUT |-> MEM_WE_N_OUT == esp_pkg::WE_IDLE && !MEM_DATA_OE_OUT)
        else $error("output enable during a write");
    rd_sample_a: assert property (
        RD_VALID_OUT |-> !$past(MEM_OE_N_OUT) && MEM_OE_N_OUT && !$past(MEM_CS_N_OUT))
        else $error("read data taken outside output enable");

    write_c: cover property (take && REQ_WRITE_IN && REQ_BE_IN == 2'h3);
    read_c: cover property (RD_VALID_OUT);
    wr_rd_c: cover property (take && REQ_WRITE_IN ##[1:10] take && !REQ_WRITE_IN);
    partial_c: cover property (take && REQ_WRITE_IN && REQ_BE_IN != 2'h3);
endmodule
`default_nettype wire

// >>> tb/esp_sram_model.sv
`default_nettype none
module esp_sram_model (
    input wire logic [esp_pkg::ADDR_W-1:0] addr_in, // Address pins
    input wire logic addr_oe_in, // Address bus driven
    input wire logic [esp_pkg::DATA_W-1:0] bus_in, // Data bus level
    input wire logic oe_n_in, // Output enable, active low
    input wire logic cs_n_in, // Chip select, active low
    input wire logic [esp_pkg::BYTES-1:0] we_n_in, // Byte strobes, active low
    output logic [esp_pkg::DATA_W-1:0] drv_out // Level the memory puts on the bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [int];
    logic [15:0] rd;
    logic [15:0] last = 16'hA5A5;
    logic [1:0] we_q = 2'h3;
    // Undriven address floats up through the pull-up
    wire [16:0] a = addr_oe_in ? addr_in : 17'h1FFFF;
    always @(posedge oe_n_in) last = rd;
    // Released bus shows the inverse, so a stale sample cannot pass
    assign drv_out = (!cs_n_in && !oe_n_in) ? rd : ~last;
    // CS rises on the same edge as the strobes, so gate on the address drive
    // Writes and the read value share one process, so a read of a word just
    // written at an unchanged address never shows the old contents
    always @(a, we_n_in) begin
        if (addr_oe_in && we_n_in[0] && !we_q[0]) mem[a][7:0] = bus_in[7:0];
        if (addr_oe_in && we_n_in[1] && !we_q[1]) mem[a][15:8] = bus_in[15:8];
        we_q = we_n_in;
        rd = mem.exists(a) ? mem[a] : ~a[15:0];
    end
endmodule
`default_nettype wire

// >>> tb/esp_sram_port_tb.sv
`default_nettype none
module esp_sram_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 1, valid = 0, wr = 0;
    logic [16:0] addr = 0;
    logic [15:0] wdata = 0;
    logic [1:0] be = 0;
    logic ready, rd_valid, addr_oe, data_oe, oe_n, cs_n;
    logic [15:0] rd_data, data_out, mem_drv;
    logic [16:0] mem_addr;
    logic [1:0] we_n;
    wire [15:0] bus = data_oe ? data_out : mem_drv;
    logic [15:0] img [int];
    logic [15:0] q [$];
    logic [16:0] al [6];
    int bad_count = 0, n_compared = 0, cyc = 0, i, r;
    initial forever #50 clk = ~clk;
    esp_sram_port u_dut (.CORE_CLOCK_IN(clk), .RESETN_IN(rst_n), .REQ_VALID_IN(valid),
        .REQ_WRITE_IN(wr), .REQ_ADDR_IN(addr), .REQ_WDATA_IN(wdata), .REQ_BE_IN(be),
        .REQ_READY_OUT(ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
        .MEM_ADDR_OUT(mem_addr), .MEM_ADDR_OE_OUT(addr_oe), .MEM_DATA_IN(bus),
        .MEM_DATA_OUT(data_out), .MEM_DATA_OE_OUT(data_oe), .MEM_OE_N_OUT(oe_n),
        .MEM_WE_N_OUT(we_n), .MEM_CS_N_OUT(cs_n));
    esp_sram_model u_mem (.addr_in(mem_addr), .addr_oe_in(addr_oe), .bus_in(bus),
        .oe_n_in(oe_n), .cs_n_in(cs_n), .we_n_in(we_n), .drv_out(mem_drv));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_pin(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected rd_data expected %h seen %h", e, g);
        end
    endtask
    task automatic idle();
        chk_pin("cs_n", 1, cs_n);
        chk_pin("oe_n", 1, oe_n);
        chk_pin("we_n", 3, we_n);
        chk_pin("bus_oe", 0, {addr_oe, data_oe});
    endtask
    task automatic acc(input logic w, input logic [16:0] a, input logic [15:0] d,
        input logic [1:0] b);
        int k;
        @(negedge clk);
        valid = 1;
        wr = w;
        addr = a;
        wdata = d;
        be = b;
        k = 0;
        // Held high while busy: the port must not take it twice
        do begin
            @(posedge clk);
            k++;
        end while (ready !== 1'b1 && k < 50);
        chk_pin("ready", 1, ready);
        if (!w) q.push_back(img[a]);
        else begin
            if (b[0]) img[a][7:0] = d[7:0];
            if (b[1]) img[a][15:8] = d[15:8];
        end
        @(negedge clk);
        chk_pin("cs_n", 0, cs_n);
        chk_pin("mem_addr", a, mem_addr);
        chk_pin("data_oe", w, data_oe);
        if (w) chk_pin("data_out", d, data_out);
        valid = 0;
    endtask
    always @(posedge clk) if (rd_valid === 1'b1) begin
        if (q.size() == 0) chk_pin("rd_valid", 0, 1);
        else chk_rd(q.pop_front(), rd_data);
    end
    always @(negedge clk) if (rst_n) begin
        if (oe_n === 1'b0 || we_n !== 2'h3) chk_pin("cs_n", 0, cs_n);
        if (data_oe === 1'b1) chk_pin("oe_n", 1, oe_n);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        r = $urandom(46255);
        // A real falling edge, so the async reset acts before the first clock
        #10 rst_n = 0;
        repeat (6) @(negedge clk);
        idle();
        rst_n = 1;
        for (i = 0; i < 6; i++) begin
            al[i] = i == 0 ? 17'h1FFFF : i == 1 ? 17'h00000 : 17'($urandom);
            acc(1, al[i], 16'($urandom), 2'h3);
        end
        for (i = 0; i < 6; i++) acc(0, al[i], 16'($urandom), 2'($urandom));
        for (i = 0; i < 3; i++) begin
            acc(1, al[i], 16'($urandom), 2'(i));
            acc(0, al[i], 16'h0000, 2'h3);
        end
        acc(1, al[1], 16'($urandom), 2'h3);
        rst_n = 0;
        repeat (2) @(negedge clk);
        idle();
        rst_n = 1;
        acc(0, al[2], 16'h0000, 2'h0);
        repeat (10) @(negedge clk);
        chk_pin("pending", 0, 17'(q.size()));
        print_verdict();
    end
endmodule
`default_nettype wire
